// *** encoder_pos_pkg.sv ***
/*
 * Package for the encoder position and analogue output control block:
 * output kinds, spans, the preset input qualification time and widths.
 * Assumes a 100 MHz clock and a 14-bit single-turn position.
 */
`default_nettype none

package encoder_pos_pkg;

    localparam int POS_W = 14;
    localparam int DAC_W = 16;

    typedef enum logic {KIND_CURRENT, KIND_VOLTAGE} out_kind_t;

    // Current spans: 0 = 4-20 mA, 1 = 0-20 mA, 2 = 0-24 mA
    // Voltage spans: 0 = 0..5, 1 = 0..10, 2 = -5..5, 3 = -10..10 V
    typedef logic [1:0] span_t;

    typedef struct packed {
        logic analog_en;
        out_kind_t kind;
        span_t span;
        logic sense_inverted;
        logic preset_en;
        logic [POS_W-1:0] preset_value;
    } cfg_t;

    // Full-scale DAC code spans 0..FFFF; span offsets in DAC codes.
    // 4 mA of 20 mA = 0x3333 as the zero point of the 4-20 span.
    localparam logic [DAC_W-1:0] CUR_4MA_CODE = 16'h3333;

    localparam logic [POS_W-1:0] PRESET_RESET = 14'h0000;

    localparam int CLK_MHZ = 100;
    localparam int PRESET_MIN_US = 100;
    localparam int PRESET_MIN_CYC = PRESET_MIN_US * CLK_MHZ;
    localparam int PCNT_W = $clog2(PRESET_MIN_CYC + 1);

endpackage : encoder_pos_pkg

`default_nettype wire

// *** encoder_position_output_control.sv ***
/*
 * Position tracking, count direction, preset load and analogue output
 * code generation for a programmable absolute encoder.
 * Assumes a sensor front end giving one-cycle up/down step pulses for
 * clockwise and counter-clockwise shaft motion, and external DACs that
 * turn the codes into current and voltage.
 * The direction and preset pins arrive from another domain and are
 * filtered here; configuration and step pulses share this clock.
 * Span scaling of the voltage output is left to the voltage DAC, so the
 * voltage code is the bare position fraction for every span.
 */
`timescale 1ns/10ps
`default_nettype none

module encoder_position_output_control (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire encoder_pos_pkg::cfg_t cfg_in,
    input wire logic step_cw_in,
    input wire logic step_ccw_in,
    input wire logic dir_invert_pin_in,
    input wire logic preset_pin_in,
    input wire logic sw_preset_in,
    input wire logic loop_break_in,
    output logic [encoder_pos_pkg::POS_W-1:0] position_out,
    output logic [encoder_pos_pkg::DAC_W-1:0] current_code_out,
    output logic current_en_out,
    output logic [encoder_pos_pkg::DAC_W-1:0] voltage_code_out,
    output logic voltage_en_out,
    output logic fault_on_out,
    output logic preset_done_out
);
    import encoder_pos_pkg::*;

    logic [2:0] inv_sync_q;
    logic [2:0] pre_sync_q;
    logic inv_q;
    logic pre_q;
    logic [PCNT_W-1:0] pcnt_q;
    logic pre_armed_q;
    logic load;
    logic up;
    logic dn;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] preset_q;
    logic [DAC_W-1:0] cur_d;
    logic [DAC_W-1:0] raw;

    // Direction pin: three flops; the level is taken once stages two and
    // three agree, so one metastable sample never flips the count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            inv_sync_q <= 3'h0;
            inv_q <= 1'b0;
        end else begin
            inv_sync_q <= {inv_sync_q[1:0], dir_invert_pin_in};
            if (inv_sync_q[1] == inv_sync_q[2]) begin
                inv_q <= inv_sync_q[2];
            end
        end
    end

    // Preset pin: same three-flop filter as the direction pin
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_sync_q <= 3'h0;
            pre_q <= 1'b0;
        end else begin
            pre_sync_q <= {pre_sync_q[1:0], preset_pin_in};
            if (pre_sync_q[1] == pre_sync_q[2]) begin
                pre_q <= pre_sync_q[2];
            end
        end
    end

    // High-time counter; it saturates at the minimum so that a long
    // press cannot wrap round and lose its qualification
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pcnt_q <= '0;
        end else if (pre_q) begin
            if (pcnt_q < PCNT_W'(PRESET_MIN_CYC)) begin
                pcnt_q <= pcnt_q + 1'b1;
            end
        end else begin
            pcnt_q <= '0;
        end
    end

    // Armed once the minimum high time has passed; short glitches never
    // arm it, and the load only fires when the level falls again
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_armed_q <= 1'b0;
        end else if (!pre_q) begin
            pre_armed_q <= 1'b0;
        end else if (pcnt_q == PCNT_W'(PRESET_MIN_CYC)) begin
            pre_armed_q <= 1'b1;
        end
    end

    assign load = sw_preset_in
        || (cfg_in.preset_en && pre_armed_q && !pre_q);

    // Preset value is latched from configuration and is zero after reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            preset_q <= PRESET_RESET;
        end else begin
            preset_q <= cfg_in.preset_value;
        end
    end

    // Direction: exclusive-or of invert pin and sense parameter
    always_comb begin
        if (inv_q ^ cfg_in.sense_inverted) begin
            up = step_ccw_in;
            dn = step_cw_in;
        end else begin
            up = step_cw_in;
            dn = step_ccw_in;
        end
    end

    // Position wraps at full turn; a load wins over a step in that cycle.
    // Steps in both directions at once cancel and leave the count alone.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pos_q <= '0;
        end else if (load) begin
            pos_q <= preset_q;
        end else if (up && !dn) begin
            pos_q <= pos_q + 1'b1;
        end else if (dn && !up) begin
            pos_q <= pos_q - 1'b1;
        end
    end

    // Done pulse: one cycle for each accepted load
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            preset_done_out <= 1'b0;
        end else begin
            preset_done_out <= load;
        end
    end

    assign position_out = pos_q;
    assign raw = {pos_q, pos_q[POS_W-1 -: DAC_W-POS_W]};

    // Current code: lowest position at span start, highest at span end.
    // 4-20 span compresses to 4/5 of scale above the 4 mA point.
    always_comb begin
        unique case (cfg_in.span)
            2'd0: cur_d = CUR_4MA_CODE
                + DAC_W'((32'(raw) * 32'd4) / 32'd5);
            2'd1: cur_d = raw;
            2'd2: cur_d = raw;
            // Span code 3 has no current meaning; full scale is the
            // safest reading of it
            default: cur_d = raw;
        endcase
    end

    // Codes are registered so the DACs never see a half-updated word
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            current_code_out <= '0;
        end else begin
            current_code_out <= cur_d;
        end
    end

    // Voltage DAC scales by span; the code is the position fraction
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            voltage_code_out <= '0;
        end else begin
            voltage_code_out <= raw;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            current_en_out <= 1'b0;
        end else begin
            current_en_out <= cfg_in.analog_en
                && cfg_in.kind == KIND_CURRENT;
        end
    end

    // Voltage stays off until the analogue gate is opened
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            voltage_en_out <= 1'b0;
        end else begin
            voltage_en_out <= cfg_in.analog_en
                && cfg_in.kind == KIND_VOLTAGE;
        end
    end

    // Switch conducts while healthy; released on error or when the
    // current kind is not selected (no indication then). A far end that
    // reads released as error must ignore it in voltage kind.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fault_on_out <= 1'b0;
        end else begin
            fault_on_out <= cfg_in.kind == KIND_CURRENT
                && !loop_break_in;
        end
    end

endmodule : encoder_position_output_control

`default_nettype wire

// *** encoder_position_output_control_asserts.sv ***
/* Checker for the position block; sees only its top ports.
   Bound below to every instance. */
`timescale 1ns/10ps
`default_nettype none
module encoder_position_output_control_asserts
    import encoder_pos_pkg::*;
(
    input wire logic clk_in, input wire logic rst_in, input wire cfg_t cfg_in,
    input wire logic step_cw_in, input wire logic step_ccw_in,
    input wire logic dir_invert_pin_in, input wire logic sw_preset_in,
    input wire logic loop_break_in, input wire logic [POS_W-1:0] position_out,
    input wire logic [DAC_W-1:0] current_code_out,
    input wire logic current_en_out, input wire logic voltage_en_out,
    input wire logic [DAC_W-1:0] voltage_code_out,
    input wire logic fault_on_out, input wire logic preset_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [1:0] age_q;
    logic [DAC_W-1:0] raw;
    // Outputs may still reflect reset-time inputs for two edges
    always_ff @(posedge clk_in) age_q <= rst_in ? 2'h0 : age_q | {age_q[0], 1'b1};
    assign raw = {position_out, position_out[13:12]};
    a_step_count: assert property (
        step_cw_in && !step_ccw_in && !sw_preset_in |=> preset_done_out ||
        position_out == $past(position_out) +
        ((dir_invert_pin_in ^ cfg_in.sense_inverted) ? 14'h3FFF : 14'h0001))
        else $error("step count");
    a_sw_load: assert property (sw_preset_in |=> preset_done_out &&
        position_out == $past(cfg_in.preset_value, 2)) else $error("sw load");
    a_done_pulse: assert property (preset_done_out &&
        !$past(sw_preset_in) |=> !preset_done_out) else $error("done pulse");
    a_cur_en: assert property (age_q == 2'h3 |-> current_en_out ==
        $past(cfg_in.analog_en && !cfg_in.kind)) else $error("cur en");
    a_volt_en: assert property (age_q == 2'h3 |-> voltage_en_out ==
        $past(cfg_in.analog_en && cfg_in.kind)) else $error("volt en");
    a_fault_flag: assert property (age_q == 2'h3 |-> fault_on_out ==
        $past(!loop_break_in && !cfg_in.kind)) else $error("fault");
    a_cur_code: assert property (age_q == 2'h3 && current_en_out &&
        $stable(cfg_in.span) |-> current_code_out == (cfg_in.span == 2'h0 ?
        CUR_4MA_CODE + 16'(32'($past(raw)) * 4 / 5) : $past(raw)))
        else $error("cur code");
    a_volt_code: assert property (age_q == 2'h3 && voltage_en_out |->
        voltage_code_out == $past(raw)) else $error("volt code");
endmodule : encoder_position_output_control_asserts
bind encoder_position_output_control encoder_position_output_control_asserts
    u_chk (.clk_in, .rst_in, .cfg_in, .step_cw_in, .step_ccw_in,
    .dir_invert_pin_in, .sw_preset_in, .loop_break_in, .position_out,
    .current_code_out, .current_en_out, .voltage_en_out, .voltage_code_out,
    .fault_on_out, .preset_done_out);
`default_nettype wire

// *** plc_model.sv ***
/* Far-side switch or controller: preset pin, direction pin, loop level.
   Tasks are called 1 ns after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module plc_model (
    input wire logic clk_in,
    output logic preset_pin_out,
    output logic inv_pin_out,
    output logic brk_out
);
    initial {preset_pin_out, inv_pin_out, brk_out} = 3'h0;
    // Caller keeps the shaft still for the whole press
    task automatic press(input int n);
        preset_pin_out = 1'b1;
        repeat (n) @(posedge clk_in);
        #1 preset_pin_out = 1'b0;
    endtask : press
    task automatic pins(input logic i, input logic b);
        inv_pin_out = i;
        brk_out = b;
    endtask : pins
endmodule : plc_model
`default_nettype wire

// *** encoder_position_output_control_tb.sv ***
/* Bench: direction, loads, analogue codes and fault of the block.
   Inputs change 1 ns after rising edges; the model drives the pins. */
`timescale 1ns/10ps
`default_nettype none
module encoder_position_output_control_tb;
    import encoder_pos_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cw = 1'b0;
    logic ccw = 1'b0;
    logic sw = 1'b0;
    cfg_t cfg = '0;
    logic pin, inv, brk, ce, ve, fo, pd;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] ep = '0;
    logic [DAC_W-1:0] cc, vc, raw;
    int fails = 0;
    int num_checks = 0;
    initial forever #5 clk = ~clk;
    encoder_position_output_control u_dut (.clk_in(clk), .rst_in(rst),
        .cfg_in(cfg), .step_cw_in(cw), .step_ccw_in(ccw), .sw_preset_in(sw),
        .dir_invert_pin_in(inv), .preset_pin_in(pin), .loop_break_in(brk),
        .position_out(pos), .current_code_out(cc), .current_en_out(ce),
        .voltage_code_out(vc), .voltage_en_out(ve), .fault_on_out(fo),
        .preset_done_out(pd));
    plc_model u_plc (.clk_in(clk), .preset_pin_out(pin), .inv_pin_out(inv),
        .brk_out(brk));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        tick(4);
        rst = 1'b0;
        tick(3);
        chk("pos", 16'(ep), 16'(pos));
        for (int k = 0; k < 4; k++) begin
            u_plc.pins(k[0], 1'b0);
            cfg.sense_inverted = k[1];
            tick(4);
            cw = 1'b1;
            tick(1);
            cw = 1'b0;
            ep += (k[0] ^ k[1]) ? 14'h3FFF : 14'h0001;
            chk("dir", 16'(ep), 16'(pos));
            ccw = 1'b1;
            tick(1);
            ccw = 1'b0;
            ep -= (k[0] ^ k[1]) ? 14'h3FFF : 14'h0001;
            chk("dir_ccw", 16'(ep), 16'(pos));
        end
        cfg.preset_value = 14'h1234;
        tick(2);
        sw = 1'b1;
        tick(1);
        sw = 1'b0;
        ep = 14'h1234;
        chk("load", 16'({ep, 1'b1}), 16'({pos, pd}));
        raw = {ep, ep[13:12]};
        cfg.analog_en = 1'b1;
        for (int s = 0; s < 3; s++) begin
            cfg.span = span_t'(s);
            tick(3);
            chk("cur", s == 0 ? CUR_4MA_CODE + 16'(32'(raw) * 4 / 5) : raw, cc);
            chk("cen", 16'h1, 16'({ve, ce}));
        end
        cfg.kind = KIND_VOLTAGE;
        tick(3);
        chk("volt", raw, vc);
        chk("ven", 16'h2, 16'({ve, fo}));
        cfg.kind = KIND_CURRENT;
        for (int b = 0; b < 2; b++) begin
            u_plc.pins(1'b1, b[0]);
            tick(3);
            chk("fault", 16'(1 - b), 16'(fo));
        end
        cfg.preset_value = 14'h0ABC;
        for (int p = 0; p < 3; p++) begin
            cfg.preset_en = p != 0;
            u_plc.press(p == 1 ? 50 : 10010);
            tick(8);
            if (p == 2) ep = 14'h0ABC;
            chk("pin", 16'(ep), 16'(pos));
        end
        results();
    end
endmodule : encoder_position_output_control_tb
`default_nettype wire
